//--- hdl/ptb_map.vh
// Constants for the PCI target back-end bridge.
// Included by ptb_decode, ptb_bridge and testbench; definitions only.
`ifndef PTB_MAP_VH
`define PTB_MAP_VH
`define PTB_CMD_IO_RD 4'h2
`define PTB_CMD_IO_WR 4'h3
`define PTB_CMD_MEM_RD 4'h6
`define PTB_CMD_MEM_WR 4'h7
`define PTB_CMD_CFG_RD 4'ha
`define PTB_CMD_CFG_WR 4'hb
`define PTB_IO_SPAN_BITS 8
`define PTB_MEM_SPAN_BITS 24
`define PTB_CFG_IDX_HI 7
`define PTB_CFG_IDX_LO 2
`define PTB_FIRST_LIMIT 5'h10
`define PTB_SUBSEQ_LIMIT 5'h08
`define PTB_TMR_W 5
`define PTB_ADDR_W 24
`endif

//--- hdl/ptb_sync.v
// Two-flop synchroniser for the back-end interrupt level.
// Assumes a single clock; input may be asynchronous.
`timescale 1ns/10ps
`default_nettype none
module ptb_sync
(
  input wire core_clk_i,
  input wire rst_n_i,
  input wire d_i,
  output wire q_o
);
  reg s1;
  reg s2;
  always @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      s1 <= 1'b1;
      s2 <= 1'b1;
    end
    else
    begin
      s1 <= d_i;
      s2 <= s1;
    end
  end
  assign q_o = s2;
endmodule
`default_nettype wire

//--- hdl/ptb_decode.v
// Command and address decoder for the PCI target.
// Assumes address phase inputs are stable in the decode cycle.
`timescale 1ns/10ps
`default_nettype none
`include "ptb_map.vh"
module ptb_decode
#(
  parameter IO_ENABLE = 1
)
(
  input wire [3:0] cmd_i,
  input wire [31:0] addr_i,
  input wire idsel_i,
  input wire [31:0] mem_base_i,
  input wire [31:0] io_base_i,
  input wire mem_en_i,
  input wire io_en_i,
  output reg hit_o,
  output reg is_read_o,
  output reg is_cfg_o
);
  always @*
  begin
    hit_o = 1'b0;
    is_read_o = 1'b0;
    is_cfg_o = 1'b0;
    case (cmd_i)
      `PTB_CMD_IO_RD, `PTB_CMD_IO_WR:
      begin
        // No address/byte-enable consistency check
        hit_o = (IO_ENABLE != 0) && io_en_i &&
          (addr_i[31:`PTB_IO_SPAN_BITS] == io_base_i[31:`PTB_IO_SPAN_BITS]);
        is_read_o = ~cmd_i[0];
      end
      `PTB_CMD_MEM_RD, `PTB_CMD_MEM_WR:
      begin
        hit_o = mem_en_i &&
          (addr_i[31:`PTB_MEM_SPAN_BITS] == mem_base_i[31:`PTB_MEM_SPAN_BITS]);
        is_read_o = ~cmd_i[0];
      end
      `PTB_CMD_CFG_RD, `PTB_CMD_CFG_WR:
      begin
        hit_o = idsel_i && (addr_i[1:0] == 2'h0);
        is_read_o = ~cmd_i[0];
        is_cfg_o = 1'b1;
      end
      default:
      begin
        hit_o = 1'b0;
      end
    endcase
  end
endmodule
`default_nettype wire

//--- hdl/ptb_bridge.v
// PCI target to generic back-end bridge, top level.
// Assumes PCI signals synchronous to core_clk_i; config regs are outside.
// Notes on behaviour
// - Read/write flags valid from begin until end
// - Pre-increment address by latency count first
// - Grant active means PCI Retry
// - Grant waits for running transfer end
// - Back-end error gives target abort
// - Back-end interrupt drives INTA when enabled
// - 0010/0011 decode as I/O read/write
// - 0110/0111 decode as memory read/write
// - 1010/1011 decode as configuration read/write
// - Build option removes I/O support
// - No I/O address/byte-enable check
// - I/O window spans 256 bytes
// - Memory window 16 MB, relocatable
// - Config claimed on IDSEL and AD[1:0]=00
// - AD[7:2] selects config dword, upper ignored
// - Zero wait burst when both keep pace
// - Back-end not ready deasserts TRDY#
// - Strobes only when ready and IRDY#
// - Ready timeout gives disconnect without data
// - Single-cycle begin and end pulses
`timescale 1ns/10ps
`default_nettype none
`include "ptb_map.vh"
module ptb_bridge
#(
  parameter IO_ENABLE = 1
)
(
  input wire core_clk_i,
  input wire rst_n_i,
  input wire frame_n_i,
  input wire irdy_n_i,
  input wire idsel_i,
  input wire [3:0] cbe_n_i,
  input wire [31:0] ad_i,
  input wire [31:0] mem_base_i,
  input wire [31:0] io_base_i,
  input wire mem_en_i,
  input wire io_en_i,
  input wire int_en_i,
  input wire [2:0] pipeline_latency_count_i,
  input wire backend_read_ready_i,
  input wire backend_write_ready_i,
  input wire backend_ownership_request_i,
  input wire backend_error_i,
  input wire backend_interrupt_low_i,
  output reg devsel_n_o,
  output reg trdy_n_o,
  output reg stop_n_o,
  output reg ctl_oe_o,
  output reg inta_n_o,
  output reg inta_oe_o,
  output reg read_transfer_flag_o,
  output reg write_transfer_flag_o,
  output reg transfer_begin_pulse_o,
  output reg transfer_end_pulse_o,
  output reg read_data_strobe_o,
  output reg [3:0] write_data_strobe_o,
  output reg cfg_access_o,
  output reg [5:0] cfg_index_o,
  output reg [`PTB_ADDR_W-1:0] mem_addr_o,
  output reg backend_ownership_grant_o
);
  localparam ST_IDLE = 3'h0;
  localparam ST_DATA = 3'h1;
  localparam ST_RETRY = 3'h2;
  localparam ST_ABORT = 3'h3;
  localparam ST_DISC = 3'h4;
  localparam ST_TURN = 3'h5;

  reg [2:0] state;
  reg [2:0] next_state;
  reg [2:0] pipe_cnt;
  reg [`PTB_TMR_W-1:0] wait_tmr;
  reg first_data;
  reg prev_frame_n;
  reg next_rd_strobe;
  reg [3:0] next_wr_strobe;
  reg next_trdy_n;
  reg next_grant;
  wire dec_hit;
  wire dec_read;
  wire dec_cfg;
  wire int_low;
  wire addr_phase;
  wire be_ready;
  wire xfer_now;
  wire tmo;

  ptb_decode #(
    .IO_ENABLE(IO_ENABLE)
  ) u_decode (
    .cmd_i(cbe_n_i),
    .addr_i(ad_i),
    .idsel_i(idsel_i),
    .mem_base_i(mem_base_i),
    .io_base_i(io_base_i),
    .mem_en_i(mem_en_i),
    .io_en_i(io_en_i),
    .hit_o(dec_hit),
    .is_read_o(dec_read),
    .is_cfg_o(dec_cfg)
  );

  ptb_sync u_int_sync (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .d_i(backend_interrupt_low_i),
    .q_o(int_low)
  );

  // Falling FRAME# marks the address phase
  assign addr_phase = prev_frame_n && !frame_n_i && (state == ST_IDLE);
  assign be_ready = read_transfer_flag_o ? backend_read_ready_i : backend_write_ready_i;
  // Data moves only when both sides are ready
  // A beat completes on the bus only with TRDY# and IRDY# both low
  assign xfer_now = (state == ST_DATA) && !trdy_n_o && !irdy_n_i;
  assign tmo = first_data ? (wait_tmr >= `PTB_FIRST_LIMIT) : (wait_tmr >= `PTB_SUBSEQ_LIMIT);

  always @*
  begin
    next_state = state;
    case (state)
      ST_IDLE:
      begin
        if (addr_phase && dec_hit)
        begin
          if (backend_ownership_grant_o)
            next_state = ST_RETRY;
          else
            next_state = ST_DATA;
        end
      end
      ST_DATA:
      begin
        if (backend_error_i)
          next_state = ST_ABORT;
        else if (tmo)
          next_state = ST_DISC;
        else if (xfer_now && frame_n_i)
          next_state = ST_TURN;
      end
      ST_RETRY, ST_ABORT, ST_DISC:
      begin
        if (frame_n_i && !irdy_n_i)
          next_state = ST_TURN;
      end
      ST_TURN:
      begin
        next_state = ST_IDLE;
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Strobe and TRDY# decisions for the coming cycle
  always @*
  begin
    next_rd_strobe = 1'b0;
    next_wr_strobe = 4'h0;
    next_trdy_n = 1'b1;
    if (state == ST_DATA && next_state == ST_DATA)
    begin
      // Latency steps strobe too; back-end discards them
      if (!irdy_n_i && backend_read_ready_i && read_transfer_flag_o)
      begin
        next_rd_strobe = 1'b1;
      end
      // Byte enables of the current data phase, made active high
      if (!irdy_n_i && backend_write_ready_i && write_transfer_flag_o)
      begin
        next_wr_strobe = ~cbe_n_i;
      end
      // No TRDY# until the latency steps are spent
      if (be_ready && pipe_cnt == 3'h0)
      begin
        next_trdy_n = 1'b0;
      end
    end
  end

  // Grant only from a quiet bus, so no claimed transfer is cut
  always @*
  begin
    next_grant = backend_ownership_grant_o;
    if (!backend_ownership_request_i)
    begin
      next_grant = 1'b0;
    end
    else if (state == ST_IDLE && !addr_phase)
    begin
      next_grant = 1'b1;
    end
  end

  always @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      state <= ST_IDLE;
      prev_frame_n <= 1'b1;
      pipe_cnt <= 3'h0;
      wait_tmr <= {`PTB_TMR_W{1'b0}};
      first_data <= 1'b0;
      devsel_n_o <= 1'b1;
      trdy_n_o <= 1'b1;
      stop_n_o <= 1'b1;
      ctl_oe_o <= 1'b0;
      inta_n_o <= 1'b1;
      inta_oe_o <= 1'b0;
      read_transfer_flag_o <= 1'b0;
      write_transfer_flag_o <= 1'b0;
      transfer_begin_pulse_o <= 1'b0;
      transfer_end_pulse_o <= 1'b0;
      read_data_strobe_o <= 1'b0;
      write_data_strobe_o <= 4'h0;
      cfg_access_o <= 1'b0;
      cfg_index_o <= 6'h0;
      mem_addr_o <= {`PTB_ADDR_W{1'b0}};
      backend_ownership_grant_o <= 1'b0;
    end
    else
    begin
      state <= next_state;
      prev_frame_n <= frame_n_i;
      transfer_begin_pulse_o <= 1'b0;
      transfer_end_pulse_o <= 1'b0;
      // Open-drain: drive low only
      inta_n_o <= 1'b0;
      inta_oe_o <= int_en_i && !int_low;
      // Grant held off while a transfer runs
      backend_ownership_grant_o <= next_grant;
      if (state == ST_IDLE && next_state == ST_DATA)
      begin
        transfer_begin_pulse_o <= 1'b1;
        read_transfer_flag_o <= dec_read;
        write_transfer_flag_o <= ~dec_read;
        cfg_access_o <= dec_cfg;
        // Function and upper bits ignored
        cfg_index_o <= ad_i[`PTB_CFG_IDX_HI:`PTB_CFG_IDX_LO];
        mem_addr_o <= ad_i[`PTB_ADDR_W-1:0];
        pipe_cnt <= pipeline_latency_count_i;
        wait_tmr <= {`PTB_TMR_W{1'b0}};
        first_data <= 1'b1;
        devsel_n_o <= 1'b0;
        trdy_n_o <= 1'b1;
        stop_n_o <= 1'b1;
        ctl_oe_o <= 1'b1;
      end
      else if (state == ST_IDLE && next_state == ST_RETRY)
      begin
        devsel_n_o <= 1'b0;
        stop_n_o <= 1'b0;
        trdy_n_o <= 1'b1;
        ctl_oe_o <= 1'b1;
      end
      if (state == ST_DATA)
      begin
        // Address runs ahead of data by the latency
        if (pipe_cnt != 3'h0 && be_ready && !irdy_n_i)
        begin
          pipe_cnt <= pipe_cnt - 3'h1;
          mem_addr_o <= mem_addr_o + {{(`PTB_ADDR_W-1){1'b0}}, 1'b1};
        end
        else if (xfer_now)
        begin
          mem_addr_o <= mem_addr_o + {{(`PTB_ADDR_W-1){1'b0}}, 1'b1};
        end
        if (xfer_now)
        begin
          wait_tmr <= {`PTB_TMR_W{1'b0}};
          first_data <= 1'b0;
        end
        else
        begin
          wait_tmr <= wait_tmr + {{(`PTB_TMR_W-1){1'b0}}, 1'b1};
        end
      end
      // Strobes track readiness of both sides
      read_data_strobe_o <= next_rd_strobe;
      write_data_strobe_o <= next_wr_strobe;
      if (state == ST_DATA)
      begin
        // TRDY# rises when back-end stalls
        trdy_n_o <= next_trdy_n;
        if (next_state == ST_ABORT)
        begin
          devsel_n_o <= 1'b1;
          stop_n_o <= 1'b0;
          trdy_n_o <= 1'b1;
        end
        else if (next_state == ST_DISC)
        begin
          stop_n_o <= 1'b0;
          trdy_n_o <= 1'b1;
        end
      end
      if (next_state == ST_TURN)
      begin
        devsel_n_o <= 1'b1;
        trdy_n_o <= 1'b1;
        stop_n_o <= 1'b1;
        if (state != ST_RETRY)
          transfer_end_pulse_o <= 1'b1;
      end
      if (state == ST_TURN)
      begin
        ctl_oe_o <= 1'b0;
        read_transfer_flag_o <= 1'b0;
        write_transfer_flag_o <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

//--- bench/ptb_chk.sv
// Port checker for the PCI target bridge.
// Sees only ptb_bridge ports; bound at the foot of this file.
`timescale 1ns/10ps
`default_nettype none
module ptb_chk
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic irdy_n_i,
  input wire logic int_en_i,
  input wire logic backend_read_ready_i,
  input wire logic backend_write_ready_i,
  input wire logic backend_error_i,
  input wire logic backend_interrupt_low_i,
  input wire logic devsel_n_o,
  input wire logic stop_n_o,
  input wire logic inta_oe_o,
  input wire logic read_transfer_flag_o,
  input wire logic write_transfer_flag_o,
  input wire logic transfer_begin_pulse_o,
  input wire logic read_data_strobe_o,
  input wire logic [3:0] write_data_strobe_o,
  input wire logic backend_ownership_grant_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // Two sync flops plus the output register
  sequence int_held;
    (int_en_i && !backend_interrupt_low_i) [*4];
  endsequence
  begin_once_a: assert property (transfer_begin_pulse_o |=> !transfer_begin_pulse_o)
    else $error("begin pulse too long");
  flag_valid_a: assert property (transfer_begin_pulse_o |->
    read_transfer_flag_o != write_transfer_flag_o) else $error("flags bad at begin");
  rd_gate_a: assert property (read_data_strobe_o |->
    $past(backend_read_ready_i && !irdy_n_i)) else $error("read strobe ungated");
  wr_gate_a: assert property (|write_data_strobe_o |->
    $past(backend_write_ready_i && !irdy_n_i)) else $error("write strobe ungated");
  retry_a: assert property (backend_ownership_grant_o && !devsel_n_o |-> !stop_n_o)
    else $error("no retry under grant");
  grant_idle_a: assert property ($rose(backend_ownership_grant_o) |-> devsel_n_o &&
    !read_transfer_flag_o && !write_transfer_flag_o) else $error("grant mid transfer");
  abort_a: assert property (backend_error_i && !devsel_n_o |->
    ##[1:2] (devsel_n_o && !stop_n_o)) else $error("no target abort");
  int_fwd_a: assert property (int_held |-> inta_oe_o)
    else $error("interrupt not forwarded");
endmodule
bind ptb_bridge ptb_chk ptb_chk_i (.core_clk_i, .rst_n_i, .irdy_n_i, .int_en_i,
  .backend_read_ready_i, .backend_write_ready_i, .backend_error_i, .backend_interrupt_low_i,
  .devsel_n_o, .stop_n_o, .inta_oe_o, .read_transfer_flag_o, .write_transfer_flag_o,
  .transfer_begin_pulse_o, .read_data_strobe_o, .write_data_strobe_o,
  .backend_ownership_grant_o);
`default_nettype wire

//--- bench/ptb_backend.sv
// Back-end model: paced ready, strobe count, ownership request.
// Mode 0 always ready, 1 every other cycle, 2 never ready.
`timescale 1ns/10ps
`default_nettype none
module ptb_backend
(
  input wire logic core_clk_i,
  input wire logic [1:0] mode_i,
  input wire logic want_i,
  input wire logic rd_strobe_i,
  input wire logic [3:0] wr_strobe_i,
  output logic read_ready_o,
  output logic write_ready_o,
  output logic request_o,
  output int strobes_o
);
  initial
  begin
    read_ready_o = 0;
    request_o = 0;
    strobes_o = 0;
  end
  assign write_ready_o = read_ready_o;
  always @(posedge core_clk_i)
  begin
    // Latency steps strobe as well; the scenario adds them to the expected count
    strobes_o <= strobes_o + (rd_strobe_i | (|wr_strobe_i));
    // Never ready forces a time-out disconnect
    read_ready_o <= #1 mode_i == 2'h0 || (mode_i == 2'h1 && !read_ready_o);
    request_o <= #1 want_i;
  end
endmodule
`default_nettype wire

//--- bench/testbench.sv
// Self-checking bench for the PCI target bridge.
// Acts as PCI master; back-end pacing comes from ptb_backend.
`timescale 1ns/10ps
`default_nettype none
`include "ptb_map.vh"
module testbench;
  logic core_clk_i = 0, rst_n_i = 0, frame_n_i = 1, irdy_n_i = 1, idsel_i = 0;
  logic mem_en_i = 1, io_en_i = 1, int_en_i = 0, backend_error_i = 0, want = 0;
  logic backend_interrupt_low_i = 1, backend_read_ready_i, backend_write_ready_i;
  logic backend_ownership_request_i, devsel_n_o, trdy_n_o, stop_n_o, ctl_oe_o;
  logic inta_n_o, inta_oe_o, read_transfer_flag_o, write_transfer_flag_o;
  logic transfer_begin_pulse_o, transfer_end_pulse_o, read_data_strobe_o;
  logic cfg_access_o, backend_ownership_grant_o, saw_dev, saw_stop, saw_abt, saw_rd;
  logic [3:0] cbe_n_i = 4'hf, write_data_strobe_o, c;
  logic [3:0] cmds [8] = '{4'h2, 4'h3, 4'h6, 4'h7, 4'ha, 4'hb, 4'h0, 4'hc};
  logic [31:0] ad_i = 0, mem_base_i = 0, io_base_i = 0, a;
  logic [2:0] pipeline_latency_count_i = 3'h0;
  logic [1:0] mode = 2'h0;
  logic [5:0] cfg_index_o, idx;
  logic [`PTB_ADDR_W-1:0] mem_addr_o, a0;
  int fails = 0, n_compared = 0, cyc = 0, seed = 79419, n_beg, n_trdy, t0, t1, strobes, s0, n;
  ptb_bridge ptb_bridge_i (.*);
  ptb_backend ptb_backend_i (.core_clk_i, .mode_i(mode), .want_i(want),
    .rd_strobe_i(read_data_strobe_o), .wr_strobe_i(write_data_strobe_o),
    .read_ready_o(backend_read_ready_i), .write_ready_o(backend_write_ready_i),
    .request_o(backend_ownership_request_i), .strobes_o(strobes));
  always #5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i)
  begin
    n_beg += transfer_begin_pulse_o;
    saw_dev |= !devsel_n_o;
    saw_stop |= !stop_n_o;
    saw_abt |= !stop_n_o && devsel_n_o;
    saw_rd |= read_transfer_flag_o;
    if (transfer_begin_pulse_o) a0 = mem_addr_o;
    if (cfg_access_o) idx = cfg_index_o;
    if (!trdy_n_o)
    begin
      if (n_trdy == 0) t0 = cyc;
      t1 = cyc;
      n_trdy++;
    end
    if (++cyc == 20000)
    begin
      fails++;
      complete_run;
    end
  end
  task automatic complete_run;
    if (fails == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (e !== g)
    begin
      fails++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  function automatic logic hit();
    case (c)
      4'h2, 4'h3: return io_en_i && a[31:8] == io_base_i[31:8];
      4'h6, 4'h7: return mem_en_i && a[31:24] == mem_base_i[31:24];
      4'ha, 4'hb: return idsel_i && a[1:0] == 2'h0;
      default: return 0;
    endcase
  endfunction
  task automatic reset_dut;
    #1 rst_n_i = 0;
    repeat (2) @(posedge core_clk_i);
    #1 rst_n_i = 1;
    chk("idle", 0, {backend_ownership_grant_o, read_data_strobe_o, write_data_strobe_o,
      transfer_begin_pulse_o, transfer_end_pulse_o});
    repeat (2) @(posedge core_clk_i);
    #1;
  endtask
  // Master side; gives up after 40 cycles like a master abort
  task automatic xfer(input int n);
    int k;
    k = 0;
    @(posedge core_clk_i) #1;
    {n_beg, n_trdy, saw_dev, saw_stop, saw_abt, saw_rd} = 0;
    s0 = strobes;
    frame_n_i = 0;
    cbe_n_i = c;
    ad_i = a;
    @(posedge core_clk_i) #1;
    frame_n_i = n == 1;
    irdy_n_i = 0;
    cbe_n_i = 4'h0;
    ad_i = $random(seed);
    repeat (40)
    begin
      @(posedge core_clk_i);
      k += !trdy_n_o;
      if (k == n || !stop_n_o) break;
      #1 frame_n_i = k >= n - 1;
    end
    #1;
    if (k < n)
    begin
      frame_n_i = 1;
      @(posedge core_clk_i) #1;
    end
    irdy_n_i = 1;
    repeat (3) @(posedge core_clk_i);
    #1;
  endtask
  initial
  begin
    reset_dut;
    mem_base_i = $random(seed) & 32'hff000000;
    io_base_i = $random(seed) & 32'hffffff00;
    foreach (cmds[i])
      for (int j = 0; j < 3; j++)
      begin
        c = cmds[i];
        a = $random(seed);
        {idsel_i, io_en_i, mem_en_i} = {3{j != 2}};
        if (c[3]) a = {a[31:11], 3'h0, a[7:2], 1'b0, j == 1};
        else if (c[2]) a = mem_base_i + (j == 1 ? 32'h01000000 : {8'h0, a[23:2], 2'h0});
        else a = io_base_i + (j == 1 ? 32'h100 : {24'h0, a[7:0]});
        xfer(1);
        chk("claim", hit(), saw_dev);
        if (!c[3]) chk("begin", hit(), n_beg);
        if (!c[3]) chk("read", hit() && !c[0], saw_rd);
        if (c[3] && hit()) chk("index", a[7:2], idx);
      end
    mem_en_i = 1;
    for (int t = 0; t < 8; t++)
    begin
      // Paced runs keep latency short so first data beats the time-out
      pipeline_latency_count_i = 3'($random(seed)) >> t[0];
      mode = t[0];
      n = 1 + {$random(seed)} % 6;
      c = t[1] ? 4'h6 : 4'h7;
      a = mem_base_i + ($random(seed) & 32'hfffffc);
      xfer(n);
      chk("beats", n, n_trdy);
      chk("strobes", n + pipeline_latency_count_i, strobes - s0);
      chk("addr", n + pipeline_latency_count_i, {8'h0, mem_addr_o - a0});
      if (mode == 2'h0) chk("gap", n - 1, t1 - t0);
    end
    want = 1;
    repeat (4) @(posedge core_clk_i);
    chk("grant", 1, backend_ownership_grant_o);
    xfer(1);
    chk("retry", 1, saw_stop && n_beg == 0 && n_trdy == 0);
    reset_dut;
    want = 0;
    pipeline_latency_count_i = 3'h0;
    repeat (4) @(posedge core_clk_i);
    #1 c = 4'h6;
    fork
      xfer(6);
      begin
        @(negedge trdy_n_o) #1 backend_error_i = 1;
        @(posedge core_clk_i) #1 backend_error_i = 0;
      end
    join
    chk("abort", 1, saw_abt && n_trdy < 6);
    mode = 2'h2;
    xfer(2);
    chk("discon", 1, saw_stop && !saw_abt && n_trdy == 0);
    int_en_i = 1;
    backend_interrupt_low_i = 0;
    repeat (5) @(posedge core_clk_i);
    chk("int", 1, inta_oe_o);
    #1 int_en_i = 0;
    repeat (5) @(posedge core_clk_i);
    chk("int_off", 0, inta_oe_o);
    complete_run;
  end
endmodule
`default_nettype wire
